/* logic/iam_top.sv */
// Input allocation mux: routes seven connector pins to logical sequence signals
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "iam_map.svh"

////////////////////////////////////////////////////////////////////////////////
module iam_top #(
  parameter int ADDR_W = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [6:0] main_io_connector,
  output logic servo_enable_in,
  output logic proportional_op_in,
  output logic forward_travel_limit_in,
  output logic reverse_travel_limit_in,
  output logic alarm_reset_in,
  output logic forward_force_limit_in,
  output logic reverse_force_limit_in,
  output logic direction_switch_in,
  output logic speed_select_a_in,
  output logic speed_select_b_in,
  output logic ctrl_method_sel_in,
  output logic zero_hold_in,
  output logic pulse_inhibit_in,
  output logic gain_sel_in,
  output logic pole_detect_in
);

  //////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  generate
    // Six address bits are the least that reach the last register
    if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr
      $error("iam_top: ADDR_W must lie between 6 and 32");
    end
    if (`IAM_PIN_N != 7 || `IAM_SIG_N != 15) begin : g_bad_count
      $error("iam_top: pin and signal counts must match the port list");
    end
    if (4 * `IAM_MAP_W != 64) begin : g_bad_map
      $error("iam_top: four maps must fill the 64-bit code vector");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Functions

  // Pick one nibble out of the four maps laid end to end
  function automatic logic [3:0] pick_code(
    input logic [63:0] maps,
    input int unsigned idx
  );
    logic [3:0] code;
    code = maps[idx*4 +: 4];
    return code;
  endfunction

  // One logical signal from its code; prim_high marks a high-active signal
  function automatic logic decode_sig(
    input logic [3:0] code,
    input logic [`IAM_PIN_N-1:0] pins,
    input logic prim_high,
    input logic no_force_on
  );
    logic [3:0] idx;
    logic level;
    logic on;
    idx = 4'h0;
    level = 1'b0;
    on = 1'b0;
    if (code <= 4'h6) begin
      idx = code;
      level = pins[idx[2:0]];
      on = prim_high ? level : ~level;
    end else if (code == `IAM_CODE_ON) begin
      // Alarm reset would never release if forced on
      on = ~no_force_on;
    end else if (code == `IAM_CODE_OFF) begin
      on = 1'b0;
    end else begin
      idx = code - `IAM_CODE_INV_BASE;
      level = pins[idx[2:0]];
      on = prim_high ? ~level : level;
    end
    return on;
  endfunction

  // All logical signals; every signal reads the same sampled pin vector
  function automatic logic [`IAM_SIG_N-1:0] decode_all(
    input logic [63:0] maps,
    input logic [`IAM_PIN_N-1:0] pins
  );
    logic [`IAM_SIG_N-1:0] sigs;
    logic [`IAM_SIG_N-1:0] prim_high;
    logic [`IAM_SIG_N-1:0] no_on;
    sigs = '0;
    prim_high = `IAM_PRIM_HIGH_MASK;
    no_on = `IAM_NO_FORCE_ON_MASK;
    for (int unsigned i = 0; i < `IAM_SIG_N; i++) begin
      // Signal i takes nibble i+1; nibble 0 is the mode field
      sigs[i] = decode_sig(pick_code(maps, i + 1), pins, prim_high[i], no_on[i]);
    end
    return sigs;
  endfunction

  function automatic logic [31:0] widen16(input logic [`IAM_MAP_W-1:0] v);
    return {16'h0000, v};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // State

  iam_pkg::iam_state_t r_reg;
  iam_pkg::iam_state_t r_next;

  logic user_mode;
  logic [`IAM_MAP_W-1:0] eff_first;
  logic [`IAM_MAP_W-1:0] eff_second;
  logic [`IAM_MAP_W-1:0] eff_third;
  logic [`IAM_MAP_W-1:0] eff_fourth;
  logic [63:0] eff_maps;
  logic pending;
  logic [31:0] addr_ext;
  logic [7:0] offset;
  logic restart;
  logic access;
  logic mapped;
  logic [31:0] read_word;

  //////////////////////////////////////////////////////////////////////////////
  // Effective allocation

  always_comb begin
    user_mode = (r_reg.act_first[3:0] == `IAM_MODE_USER);
    // Mode and the first two maps come from the copies latched at restart
    eff_first = user_mode ? r_reg.act_first : `IAM_FIX_FIRST;
    eff_second = user_mode ? r_reg.act_second : `IAM_FIX_SECOND;
    // Third and fourth maps are live; no restart is needed for them
    eff_third = user_mode ? r_reg.map_third : `IAM_FIX_THIRD;
    eff_fourth = user_mode ? r_reg.map_fourth : `IAM_FIX_FOURTH;
    eff_maps = {eff_fourth, eff_third, eff_second, eff_first};
    pending = (r_reg.act_first != r_reg.map_first) || (r_reg.act_second != r_reg.map_second);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register read decode

  always_comb begin
    // Widened first so the upper-bit test stays legal on a narrow bus
    addr_ext = 32'(paddr);
    offset = addr_ext[7:0];
    access = psel && penable;
    mapped = 1'b1;
    read_word = 32'h0000_0000;
    if (addr_ext[31:8] != 24'h000000 || addr_ext[1:0] != 2'h0) begin
      mapped = 1'b0;
    end else begin
      case (offset)
        `IAM_OFF_FIRST: begin
          read_word = widen16(r_reg.map_first);
        end
        `IAM_OFF_SECOND: begin
          read_word = widen16(r_reg.map_second);
        end
        `IAM_OFF_THIRD: begin
          read_word = widen16(r_reg.map_third);
        end
        `IAM_OFF_FOURTH: begin
          read_word = widen16(r_reg.map_fourth);
        end
        `IAM_OFF_CTRL: begin
          read_word = 32'h0000_0000;
        end
        `IAM_OFF_STATUS: begin
          read_word[`IAM_STAT_PENDING_BIT] = pending;
          read_word[`IAM_STAT_USER_BIT] = user_mode;
        end
        `IAM_OFF_PINS: begin
          read_word = {25'h0000000, r_reg.pin};
        end
        `IAM_OFF_SIGS: begin
          read_word = {17'h00000, r_reg.sig};
        end
        `IAM_OFF_ACT_FIRST: begin
          read_word = widen16(r_reg.act_first);
        end
        `IAM_OFF_ACT_SECOND: begin
          read_word = widen16(r_reg.act_second);
        end
        default: begin
          mapped = 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Restart strobe

  // Only the completing edge of a mapped write to control counts
  always_comb begin
    restart = 1'b0;
    if (r_reg.bus_state == iam_pkg::IAM_ST_ANSWER && access && pwrite && mapped) begin
      restart = (offset == `IAM_OFF_CTRL) && pwdata[`IAM_CTRL_RESTART_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    r_next = r_reg;
    // Pins are sampled once so all sharing signals see one level
    r_next.pin = main_io_connector;
    r_next.sig = decode_all(eff_maps, r_reg.pin);
    case (r_reg.bus_state)
      iam_pkg::IAM_ST_IDLE: begin
        r_next.pready = 1'b0;
        r_next.pslverr = 1'b0;
        if (access) begin
          // One wait state keeps the read mux off the output path
          r_next.bus_state = iam_pkg::IAM_ST_ANSWER;
          r_next.pready = 1'b1;
          r_next.pslverr = ~mapped;
          r_next.prdata = pwrite ? 32'h0000_0000 : read_word;
        end
      end
      iam_pkg::IAM_ST_ANSWER: begin
        r_next.bus_state = iam_pkg::IAM_ST_IDLE;
        r_next.pready = 1'b0;
        r_next.pslverr = 1'b0;
        if (access && pwrite && mapped) begin
          case (offset)
            `IAM_OFF_FIRST: begin
              r_next.map_first = pwdata[15:0];
            end
            `IAM_OFF_SECOND: begin
              r_next.map_second = pwdata[15:0];
            end
            `IAM_OFF_THIRD: begin
              r_next.map_third = pwdata[15:0];
            end
            `IAM_OFF_FOURTH: begin
              r_next.map_fourth = pwdata[15:0];
            end
            `IAM_OFF_CTRL: begin
              // Soft restart stands in for the power cycle
              if (restart) begin
                r_next.act_first = r_reg.map_first;
                r_next.act_second = r_reg.map_second;
              end
            end
            // Read-only registers take writes silently
            `IAM_OFF_STATUS: begin
            end
            `IAM_OFF_PINS: begin
            end
            `IAM_OFF_SIGS: begin
            end
            `IAM_OFF_ACT_FIRST: begin
            end
            `IAM_OFF_ACT_SECOND: begin
            end
            default: begin
              r_next.map_first = r_reg.map_first;
            end
          endcase
        end
      end
      default: begin
        r_next.bus_state = iam_pkg::IAM_ST_IDLE;
        r_next.pready = 1'b0;
        r_next.pslverr = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clock) begin
    if (rst) begin
      r_reg.bus_state <= iam_pkg::IAM_ST_IDLE;
      r_reg.pready <= 1'b0;
      r_reg.pslverr <= 1'b0;
      r_reg.prdata <= 32'h0000_0000;
      r_reg.map_first <= `IAM_RST_FIRST;
      r_reg.map_second <= `IAM_RST_SECOND;
      r_reg.map_third <= `IAM_RST_THIRD;
      r_reg.map_fourth <= `IAM_RST_FOURTH;
      r_reg.act_first <= `IAM_RST_FIRST;
      r_reg.act_second <= `IAM_RST_SECOND;
      r_reg.pin <= 7'h7f;
      r_reg.sig <= 15'h0000;
    end else begin
      r_reg <= r_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Every output is a register bit; no decode sits between flops and pins
  // Signal order follows nibble order, servo enable first
  always_comb begin
    prdata = r_reg.prdata;
    pready = r_reg.pready;
    pslverr = r_reg.pslverr;
    servo_enable_in = r_reg.sig[0];
    proportional_op_in = r_reg.sig[1];
    forward_travel_limit_in = r_reg.sig[2];
    reverse_travel_limit_in = r_reg.sig[3];
    alarm_reset_in = r_reg.sig[4];
    forward_force_limit_in = r_reg.sig[5];
    reverse_force_limit_in = r_reg.sig[6];
    direction_switch_in = r_reg.sig[7];
    speed_select_a_in = r_reg.sig[8];
    speed_select_b_in = r_reg.sig[9];
    ctrl_method_sel_in = r_reg.sig[10];
    zero_hold_in = r_reg.sig[11];
    pulse_inhibit_in = r_reg.sig[12];
    gain_sel_in = r_reg.sig[13];
    pole_detect_in = r_reg.sig[14];
  end

endmodule

/* include/iam_map.svh */
// Offsets, field positions, reset values and codes of the input allocation mux
`ifndef IAM_MAP_SVH
`define IAM_MAP_SVH

`define IAM_MAP_W 16
`define IAM_PIN_N 7
`define IAM_SIG_N 15
`define IAM_DATA_W 32

`define IAM_OFF_FIRST 8'h00
`define IAM_OFF_SECOND 8'h04
`define IAM_OFF_THIRD 8'h08
`define IAM_OFF_FOURTH 8'h0c
`define IAM_OFF_CTRL 8'h10
`define IAM_OFF_STATUS 8'h14
`define IAM_OFF_PINS 8'h18
`define IAM_OFF_SIGS 8'h1c
`define IAM_OFF_ACT_FIRST 8'h20
`define IAM_OFF_ACT_SECOND 8'h24

`define IAM_CTRL_RESTART_BIT 0
`define IAM_STAT_PENDING_BIT 0
`define IAM_STAT_USER_BIT 1

`define IAM_MODE_USER 4'h1
`define IAM_CODE_ON 4'h7
`define IAM_CODE_OFF 4'h8
`define IAM_CODE_INV_BASE 4'h9

`define IAM_RST_FIRST 16'h2100
`define IAM_RST_SECOND 16'h6543
`define IAM_RST_THIRD 16'h8888
`define IAM_RST_FOURTH 16'h8888

`define IAM_FIX_FIRST 16'h2100
`define IAM_FIX_SECOND 16'h6543
`define IAM_FIX_THIRD 16'h8888
`define IAM_FIX_FOURTH 16'h8888

`define IAM_PRIM_HIGH_MASK 15'h000c
`define IAM_NO_FORCE_ON_MASK 15'h0010

`endif

/* include/iam_pkg.sv */
// Types of the input allocation mux
`include "iam_map.svh"
package iam_pkg;

  typedef enum logic [0:0] {
    IAM_ST_IDLE,
    IAM_ST_ANSWER
  } iam_bus_state_t;

  typedef struct packed {
    iam_bus_state_t bus_state;
    logic pready;
    logic pslverr;
    logic [`IAM_DATA_W-1:0] prdata;
    logic [`IAM_MAP_W-1:0] map_first;
    logic [`IAM_MAP_W-1:0] map_second;
    logic [`IAM_MAP_W-1:0] map_third;
    logic [`IAM_MAP_W-1:0] map_fourth;
    logic [`IAM_MAP_W-1:0] act_first;
    logic [`IAM_MAP_W-1:0] act_second;
    logic [`IAM_PIN_N-1:0] pin;
    logic [`IAM_SIG_N-1:0] sig;
  } iam_state_t;

endpackage

/* sim/iam_top_assertions.sv */
// Checker of bus handshake and signal settling of the input mux
`timescale 1ns/1ps
module iam_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [6:0] main_io_connector,
  input wire logic servo_enable_in,
  input wire logic forward_travel_limit_in,
  input wire logic forward_force_limit_in,
  input wire logic direction_switch_in,
  input wire logic zero_hold_in
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire acc = psel && penable;
  wire bad = paddr[1:0] != 2'h0 || 32'(paddr) > 32'h0000_0024;
  wire [4:0] sv = {servo_enable_in, forward_travel_limit_in, forward_force_limit_in,
    direction_switch_in, zero_hold_in};
  ////////////////////////////////////////
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  AST_WAIT_STATE: assert property (acc && $rose(penable) |-> !pready ##1 pready)
    else $error("access phase not two cycles");
  AST_READY_IN_ACCESS: assert property (pready |-> acc && $past(acc))
    else $error("pready outside an access phase");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without pready or with data");
  AST_UNMAPPED: assert property (pready && bad |-> pslverr)
    else $error("bad address not refused");
  AST_MAPPED_OK: assert property (pready && !bad |-> !pslverr)
    else $error("mapped address refused");
  AST_UPPER_ZERO: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
    else $error("upper read bits not zero");
  // Bus quiet and pins still: any map or restart effect has landed by now
  AST_SIGS_SETTLE: assert property (($stable(main_io_connector) && !psel) [*4] |-> $stable(sv))
    else $error("signals move with pins and bus still");
  cover property (pready && pslverr);
  cover property (pready && pwrite);
  cover property ($changed(sv));
endmodule

bind iam_top iam_checker #(.ADDR_W(ADDR_W)) u_chk (
  .clock, .rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .main_io_connector, .servo_enable_in, .forward_travel_limit_in,
  .forward_force_limit_in, .direction_switch_in, .zero_hold_in
);

/* sim/iam_contacts.sv */
// Contact bank driving the connector pins
`timescale 1ns/1ps
module iam_contacts (
  input wire logic clock,
  input wire logic [6:0] level_req,
  output logic [6:0] main_io_connector
);
  // Open contacts read high until the bench closes one
  initial main_io_connector = 7'h7f;
  // Contacts settle one cycle after the request, like a slow relay
  always @(posedge clock) begin
    main_io_connector <= level_req;
  end
endmodule

/* sim/tb_input_signal_allocation_mux.sv */
// Self-checking bench of the input allocation mux
`timescale 1ns/1ps
module tb_input_signal_allocation_mux;
  logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr;
  logic [6:0] main_io_connector, lv = 7'h7f;
  wire [14:0] s;
  int n_mismatch, n_compared;
  // Factory layout, fourth map in the top 16 bits
  localparam logic [63:0] FX = 64'h8888_8888_6543_2100;
  // Servo enable and the forward limits kept on plain codes
  localparam logic [63:0] UM = 64'h827e_7f06_9578_3a51;
  always #2.5 clock = ~clock;
  iam_contacts u_pins (.clock, .level_req(lv), .main_io_connector);
  iam_top dut (
    .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .main_io_connector, .servo_enable_in(s[0]), .proportional_op_in(s[1]),
    .forward_travel_limit_in(s[2]), .reverse_travel_limit_in(s[3]),
    .alarm_reset_in(s[4]), .forward_force_limit_in(s[5]), .reverse_force_limit_in(s[6]),
    .direction_switch_in(s[7]), .speed_select_a_in(s[8]), .speed_select_b_in(s[9]),
    .ctrl_method_sel_in(s[10]), .zero_hold_in(s[11]), .pulse_inhibit_in(s[12]),
    .gain_sel_in(s[13]), .pole_detect_in(s[14])
  );
  ////////////////////////////////////////
  function automatic logic [14:0] ex(input logic [63:0] m, input logic [6:0] p);
    logic [3:0] c;
    logic h;
    for (int i = 0; i < 15; i++) begin
      c = m[4*i+4 +: 4];
      h = (i == 2 || i == 3);
      if (c == 4'h7) ex[i] = (i != 4);
      else if (c == 4'h8) ex[i] = 1'b0;
      else if (c < 4'h7) ex[i] = (p[c] == h);
      else ex[i] = (p[c-4'h9] != h);
    end
  endfunction
  task automatic test_done();
    if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_mismatch++;
      $display("wrong value at %0t: no pready", $time);
      test_done();
    end
    @(posedge clock);
  endtask
  // Walks one pin high at a time, then all high, then all low
  task automatic sweep(input logic [63:0] m);
    logic [6:0] p;
    for (int k = 0; k < 9; k++) begin
      p = (k < 7) ? 7'h01 << k : {7{k[0]}};
      lv <= p;
      repeat (4) @(posedge clock);
      chk(32'(s), 32'(ex(m, p)));
    end
  endtask
  ////////////////////////////////////////
  initial begin
    n_mismatch = 0;
    n_compared = 0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(q, 32'(FX[16*i +: 16]));
    end
    sweep(FX);
    for (int i = 0; i < 4; i++) apb(1'b1, 8'(4 * i), 32'(UM[16*i +: 16]));
    // Pending set, user mode not yet live
    apb(1'b0, 8'h14, 32'h0);
    chk(q, 32'h1);
    sweep(FX);
    apb(1'b1, 8'h10, 32'h1);
    apb(1'b0, 8'h14, 32'h0);
    chk(q, 32'h2);
    sweep(UM);
    apb(1'b0, 8'h18, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    chk(q, 32'(ex(UM, 7'h00)));
    apb(1'b1, 8'h00, 32'hffff_3a50);
    apb(1'b1, 8'h10, 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h3a50);
    sweep(FX);
    apb(1'b0, 8'h28, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    apb(1'b1, 8'h02, 32'h5);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h3a50);
    // Power cycle brings back the factory maps
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    apb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h2100);
    apb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h2100);
    sweep(FX);
    test_done();
  end
endmodule
